// [sim/pw_sink.sv]
// Host model that takes port-write packets off the notifier's packet port.
// Assumes the notifier holds pw_valid and its fields until pw_ready is seen high.
`timescale 1ns/1ps
module pw_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Packet handshake
  input wire logic pw_valid,
  input wire logic slow,
  output logic pw_ready
);
  logic [1:0] phase_reg;
  // Phase moves only while a packet is offered, so slow mode stalls every packet
  always_ff @(posedge clk) begin
    if (!rst_n) phase_reg <= 2'h0;
    else if (pw_valid) phase_reg <= phase_reg + 2'h1;
  end
  // Slow mode takes one cycle in four, so held packets are exercised
  assign pw_ready = rst_n && (!slow || phase_reg == 2'h3);
endmodule : pw_sink

// [sim/tb_port_write_notifier.sv]
// Self-checking bench for the port-write notifier with a behavioural model.
// Assumes pwn_pkg and the pw_sink host model are compiled first.
`timescale 1ns/1ps
module tb_port_write_notifier
  import pwn_pkg::*;
;
  localparam logic [7:0] PNUM = 8'h05;
  localparam int LT = 16;
  localparam logic [127:0] PM = {32'h1, {96{1'b1}}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, capture_word = 32'h0, lt_err_detect = 32'h0, reg_rdata, cap_old;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ack_start = 1'b0, ack_done = 1'b0, mc_hit = 1'b0, slow = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [IMPL_W-1:0] impl = '0;
  logic [7:0] mc_mask = 8'h00, pw_src, pw_hop, pw_mc_mask;
  logic pw_ready, pw_valid, pw_to_mc;
  logic [DEST_W-1:0] pw_dest, x_dest;
  logic [PRIO_W-1:0] pw_prio, m_prio = 2'h3;
  logic [PAYLOAD_W-1:0] pw_payload;
  logic [15:0] rnd = 16'h0021;
  logic [154:0] cur = '0;
  logic [154:0] exp_q[$];
  int failures = 0, checks = 0, n_seen = 0, n_exp = 0;
  int m_errdet = 0, m_intstat = 0, m_inten = 0, m_pend = 0, m_dis = 0;

  always #2.5 clk = ~clk;

  port_write_notifier #(.NUM_PORTS(8), .PORT_NUM(PNUM), .TIMER_W(24), .RESEND_RESET(24'h000000),
    .LTCTL_RESET(24'h000010)) port_write_notifier_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_bad_ackid(ev[0]), .ev_protocol(ev[1]),
    .ev_delineation(ev[2]), .ev_unsol_ack(ev[3]), .ack_wait_start(ack_start), .ack_wait_done(ack_done),
    .capture_word(capture_word), .impl_evt(impl), .lt_err_detect(lt_err_detect), .mc_group_hit(mc_hit),
    .mc_group_mask(mc_mask), .pw_ready(pw_ready), .pw_valid(pw_valid), .pw_dest(pw_dest),
    .pw_prio(pw_prio), .pw_src(pw_src), .pw_hop(pw_hop), .pw_payload(pw_payload),
    .pw_to_mc(pw_to_mc), .pw_mc_mask(pw_mc_mask));

  pw_sink pw_sink_inst (.clk(clk), .rst_n(rst_n), .pw_valid(pw_valid), .slow(slow), .pw_ready(pw_ready));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk) reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rd

  // Predicts issue at the edge that samples the event; later events while pending are dropped
  task automatic model(input int err, input int im);
    m_errdet |= err;
    m_intstat |= im << 12;
    if ((((im << 12) | err) & m_inten) != 0 && m_pend == 0 && m_dis == 0) begin
      m_pend = 1;
      n_exp++;
      exp_q.push_back({mc_hit ? (mc_mask & ~(8'h01 << PNUM)) : 8'h00, mc_hit, m_prio, x_dest,
        32'h1, 32'(m_errdet), PNUM, 12'(m_intstat >> 12), 12'h0, lt_err_detect});
    end
  endtask : model

  task automatic fire(input logic [3:0] e, input logic [11:0] im);
    @(posedge clk);
    ev <= e;
    impl <= im;
    @(posedge clk);
    ev <= 4'h0;
    impl <= '0;
    model(e, im);
    repeat (12) @(posedge clk);
  endtask : fire

  // Error detect goes first: a pending clear is refused while it holds bits
  task automatic clear();
    wr(ERRDET_OFS, ERR_MASK);
    wr(INTSTAT_OFS, IMPL_MASK);
    wr(ERRSTAT_OFS, 32'h1);
    m_errdet = 0;
    m_intstat = 0;
    m_pend = 0;
  endtask : clear

  // First send of an issue is compared in full, resends against the same destination
  always @(posedge clk) begin
    if (pw_valid === 1'b1 && pw_ready === 1'b1) begin
      n_seen++;
      check({pw_src, pw_hop}, {SRC_ID, HOP_COUNT});
      if (exp_q.size() > 0) begin
        cur = exp_q.pop_front();
        check({pw_to_mc ? pw_mc_mask : 8'h00, pw_to_mc, pw_prio, pw_dest, pw_payload & PM}, cur);
      end
      else check(pw_dest, cur[143:128]);
    end
  end

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(PRIO_OFS, 32'h3);
    rd(MODE_OFS, 32'h0);
    rd(OUTST_OFS, 32'h0);
    rd(8'hfc, 32'h0);
    rnd = lfsr(rnd);
    x_dest = rnd;
    wr(TARGET_OFS, {16'h0, rnd});
    rd(TARGET_OFS, {16'h0, x_dest});
    rnd = lfsr(rnd);
    cap_old = {rnd, ~rnd};
    capture_word <= cap_old;
    lt_err_detect <= {~rnd, rnd};
    m_inten = ERR_MASK | IMPL_MASK;
    wr(INTEN_OFS, m_inten);
    fire(4'h2, 12'h0);
    rd(ERRSTAT_OFS, 32'h1);
    rd(OUTST_OFS, 32'h1 << PNUM);
    rd(CAPTURE_OFS, cap_old);
    fire(4'h4, 12'h0);
    check(n_seen, n_exp);
    rd(ERRDET_OFS, 32'h6);
    wr(ERRSTAT_OFS, 32'h1);
    rd(ERRSTAT_OFS, 32'h1);
    clear();
    rd(ERRSTAT_OFS, 32'h0);
    rd(OUTST_OFS, 32'h0);
    wr(MODE_OFS, 32'h1);
    m_dis = 1;
    rnd = lfsr(rnd);
    capture_word <= {rnd, rnd};
    fire(4'h1, 12'h0);
    check(n_seen, n_exp);
    rd(ERRDET_OFS, 32'h1);
    rd(CAPTURE_OFS, cap_old);
    wr(MODE_OFS, 32'h0);
    m_dis = 0;
    clear();
    m_inten = IMPL_MASK;
    wr(INTEN_OFS, m_inten);
    fire(4'h8, 12'h0);
    check(n_seen, n_exp);
    rd(CAPTURE_OFS, {rnd, rnd});
    clear();
    wr(PRIO_OFS, 32'h1);
    m_prio = 2'h1;
    slow <= 1'b1;
    mc_hit <= 1'b1;
    mc_mask <= rnd[7:0] | (8'h01 << PNUM);
    fire(4'h0, 12'h801);
    wr(ERRSTAT_OFS, 32'h1);
    m_pend = 0;
    fire(4'h0, 12'h801);
    check(n_seen, n_exp);
    rd(INTSTAT_OFS, 32'h00801000);
    clear();
    slow <= 1'b0;
    mc_hit <= 1'b0;
    m_inten = ERR_MASK | IMPL_MASK;
    wr(INTEN_OFS, m_inten);
    wr(RESEND_OFS, 32'h8);
    rd(RESEND_OFS, 32'h8);
    fire(4'h2, 12'h0);
    repeat (30) @(posedge clk);
    check(n_seen >= n_exp + 3, 1'b1);
    clear();
    wr(RESEND_OFS, 32'h0);
    repeat (4) @(posedge clk);
    n_exp = n_seen;
    repeat (30) @(posedge clk);
    check(n_seen, n_exp);
    rd(LTCTL_OFS, 32'h10);
    @(posedge clk) ack_start <= 1'b1;
    @(posedge clk) ack_start <= 1'b0;
    repeat (4) @(posedge clk);
    ack_done <= 1'b1;
    @(posedge clk) ack_done <= 1'b0;
    repeat (LT + 10) @(posedge clk);
    rd(ERRDET_OFS, 32'h0);
    @(posedge clk) ack_start <= 1'b1;
    @(posedge clk) ack_start <= 1'b0;
    model(16, 0);
    repeat (LT + 10) @(posedge clk);
    rd(ERRDET_OFS, 32'h10);
    check(n_seen, n_exp);
    results();
  end
endmodule : tb_port_write_notifier

// [verilog/port_write_notifier.sv]
// Per-port port-write notifier: error detect, status, payload build and resend.
// Assumes a host on a plain register port and a downstream packet path with ready.
// Function
// - Generation enabled after reset; disable field blocks new issues for this port, not timer resends.
// - Each enabled event sends a port-write to the programmed target ID, unless disabled, pending or a packet is still waiting.
// - Events whose interrupt enable is clear send no port-write.
// - Every qualifying event counts, even with its status bit already set.
// - One outstanding port-write; events meanwhile send nothing.
// - Outstanding-request register shows ports with uncleared port-writes.
// - Resend timer reissues the port-write on each expiry until cleared.
// - One device-wide destination ID, mapped by software in routing tables.
// - Payload is 16 bytes of status, port identity and implementation status.
// - Packets go at the programmable priority, reset value 3.
// - Source ID 0x00 and hop count 0xFF on every packet.
// - Port number in bits 24 to 31 of payload word at offset 0x8.
// - Same word copies the twelve implementation status bits 12 to 23.
// - Issuing a port-write sets the pending bit.
// - Multicast-group destination goes to the multicast engine.
// - Originating port removed from the multicast mask.
// - Bad link-response ackID sets its detect bit, no capture.
// - Unexpected packet or symbol sets protocol fault and captures.
// - Delineation fault sets its bit, no capture.
// - Unsolicited acknowledge sets its bit and captures.
// - Missing acknowledge within link time-out interval sets its bit, no capture.
`timescale 1ns/1ps
module port_write_notifier
  import pwn_pkg::*;
#(
  parameter int NUM_PORTS = 8,
  parameter logic [PORTID_W-1:0] PORT_NUM = 8'h00,
  parameter int TIMER_W = 24,
  parameter logic [TIMER_W-1:0] RESEND_RESET = 24'h000000,
  parameter logic [TIMER_W-1:0] LTCTL_RESET = 24'h000fff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link error events, one-cycle pulses
  input wire logic ev_bad_ackid,
  input wire logic ev_protocol,
  input wire logic ev_delineation,
  input wire logic ev_unsol_ack,
  input wire logic ack_wait_start,
  input wire logic ack_wait_done,
  input wire logic [31:0] capture_word,
  // Implementation status events, bit i maps to status bit 12+i
  input wire logic [IMPL_W-1:0] impl_evt,
  input wire logic [31:0] lt_err_detect,
  // Multicast lookup of the target ID
  input wire logic mc_group_hit,
  input wire logic [NUM_PORTS-1:0] mc_group_mask,
  // Port-write packet out
  input wire logic pw_ready,
  output logic pw_valid,
  output logic [DEST_W-1:0] pw_dest,
  output logic [PRIO_W-1:0] pw_prio,
  output logic [7:0] pw_src,
  output logic [7:0] pw_hop,
  output logic [PAYLOAD_W-1:0] pw_payload,
  output logic pw_to_mc,
  output logic [NUM_PORTS-1:0] pw_mc_mask
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } pw_state_e;

  pw_state_e state_reg;
  logic notify_disable_reg;
  logic [DEST_W-1:0] target_reg;
  logic [TIMER_W-1:0] resend_interval_reg;
  logic [PRIO_W-1:0] notify_priority_reg;
  logic notify_pending_reg;
  logic [ERR_W-1:0] errdet_reg;
  logic [IMPL_W-1:0] intstat_reg;
  logic [31:0] inten_reg;
  logic [31:0] capture_reg;
  logic [TIMER_W-1:0] link_timeout_ctrl_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] lt_cnt_reg;
  logic lt_active_reg;
  logic [NUM_PORTS-1:0] outstanding_reg;

  logic wr_errstat;
  logic wr_errdet;
  logic wr_intstat;
  logic ack_wait_expired;
  logic [ERR_W-1:0] err_evt;
  logic [IMPL_W-1:0] impl_en;
  logic fire;
  logic issue;
  logic clear_pending;
  logic timer_expired;
  logic [31:0] errstat_word;
  logic [31:0] errdet_word;
  logic [31:0] intstat_word;
  logic [31:0] impl_word;
  logic [NUM_PORTS-1:0] own_bit;
  logic [ERR_W-1:0] errdet_next;
  logic [IMPL_W-1:0] intstat_next;
  logic [31:0] errdet_now_word;

  assign wr_errstat = reg_wr && (reg_addr == ERRSTAT_OFS);
  assign wr_errdet = reg_wr && (reg_addr == ERRDET_OFS);
  assign wr_intstat = reg_wr && (reg_addr == INTSTAT_OFS);

  // Link time-out counter runs while an acknowledge is awaited
  assign ack_wait_expired = lt_active_reg && (lt_cnt_reg == link_timeout_ctrl_reg);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lt_active_reg <= 1'b0;
      lt_cnt_reg <= '0;
    end else if (ack_wait_done || ack_wait_expired) begin
      lt_active_reg <= 1'b0;
      lt_cnt_reg <= '0;
    end else if (ack_wait_start) begin
      lt_active_reg <= 1'b1;
      lt_cnt_reg <= '0;
    end else if (lt_active_reg) begin
      lt_cnt_reg <= lt_cnt_reg + 1'b1;
    end
  end

  // Error event vector in detect-register order
  assign err_evt[ERR_BAD_ACKID] = ev_bad_ackid;
  assign err_evt[ERR_PROTOCOL] = ev_protocol;
  assign err_evt[ERR_DELIN] = ev_delineation;
  assign err_evt[ERR_UNSOL_ACK] = ev_unsol_ack;
  assign err_evt[ERR_ACK_WAIT] = ack_wait_expired;

  // Next detect and status values; the payload takes them so a packet shows its own cause
  assign errdet_next = (errdet_reg & ~(wr_errdet ? reg_wdata[ERR_W-1:0] : '0)) | err_evt;
  assign intstat_next = (intstat_reg & ~(wr_intstat ? reg_wdata[IMPL_LSB +: IMPL_W] : '0)) | impl_evt;

  // Detect bits are write-one-to-clear; a new event beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errdet_reg <= '0;
    end else begin
      errdet_reg <= errdet_next;
    end
  end

  // Only protocol and unsolicited-acknowledge faults latch the capture word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture_reg <= ZERO_WORD;
    end else if (ev_protocol || ev_unsol_ack) begin
      capture_reg <= capture_word;
    end
  end

  // Implementation status bits, also write-one-to-clear with set winning
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intstat_reg <= '0;
    end else begin
      intstat_reg <= intstat_next;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      notify_disable_reg <= 1'b0;
      target_reg <= '0;
      resend_interval_reg <= RESEND_RESET;
      notify_priority_reg <= PRIO_RESET;
      inten_reg <= ZERO_WORD;
      link_timeout_ctrl_reg <= LTCTL_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        MODE_OFS: notify_disable_reg <= reg_wdata[DISABLE_BIT];
        TARGET_OFS: target_reg <= reg_wdata[DEST_W-1:0];
        RESEND_OFS: resend_interval_reg <= reg_wdata[TIMER_W-1:0];
        PRIO_OFS: notify_priority_reg <= reg_wdata[PRIO_LSB +: PRIO_W];
        INTEN_OFS: inten_reg <= reg_wdata & (ERR_MASK | IMPL_MASK);
        LTCTL_OFS: link_timeout_ctrl_reg <= reg_wdata[TIMER_W-1:0];
        default: ;
      endcase
    end
  end

  // Any fresh enabled event qualifies, whatever its status bit holds
  assign impl_en = inten_reg[IMPL_LSB +: IMPL_W];
  assign fire = (|(err_evt & inten_reg[ERR_W-1:0])) || (|(impl_evt & impl_en));
  // A packet still waiting for the sink also holds off new events, so none is lost
  assign issue = fire && !notify_disable_reg && !notify_pending_reg && !pw_valid;
  // Pending only clears once the detect register is already clean
  assign clear_pending = wr_errstat && reg_wdata[PENDING_BIT] && (errdet_reg == '0);
  assign timer_expired = (state_reg == ST_WAIT) && (resend_interval_reg != '0) && (timer_reg == '0);

  // Pending bit; issue wins over a clear in the same cycle, so a new packet stays pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      notify_pending_reg <= 1'b0;
    end else if (issue) begin
      notify_pending_reg <= 1'b1;
    end else if (clear_pending) begin
      notify_pending_reg <= 1'b0;
    end
  end

  // Send sequencer: send, then wait for clear or the resend timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (issue) state_reg <= ST_SEND;
        ST_SEND: if (pw_ready) state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (issue) begin
            state_reg <= ST_SEND;
          end else if (!notify_pending_reg) begin
            state_reg <= ST_IDLE;
          end else if (timer_expired) begin
            state_reg <= ST_SEND;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Resend timer reloads after each send; zero interval means send once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else if (state_reg == ST_SEND) begin
      timer_reg <= resend_interval_reg - 1'b1;
    end else if (state_reg == ST_WAIT && timer_reg != '0) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  // Payload words
  assign errstat_word = {{(32-1){1'b0}}, notify_pending_reg};
  assign errdet_word = {{(32-ERR_W){1'b0}}, errdet_reg};
  assign intstat_word = {{(32-IMPL_LSB-IMPL_W){1'b0}}, intstat_reg, {IMPL_LSB{1'b0}}};
  assign errdet_now_word = {{(32-ERR_W){1'b0}}, errdet_next};
  assign impl_word = {PORT_NUM, intstat_next, {IMPL_LSB{1'b0}}};

  // Own port bit for the multicast mask
  generate
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_own
      assign own_bit[i] = (i == int'(PORT_NUM));
    end
  endgenerate

  // Packet registers; payload refreshed on every send, held while valid
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pw_valid <= 1'b0;
      pw_dest <= '0;
      pw_prio <= PRIO_RESET;
      pw_src <= SRC_ID;
      pw_hop <= HOP_COUNT;
      pw_payload <= '0;
      pw_to_mc <= 1'b0;
      pw_mc_mask <= '0;
    end else if (pw_valid) begin
      if (pw_ready) pw_valid <= 1'b0;
    end else if (issue || (timer_expired && notify_pending_reg)) begin
      pw_valid <= 1'b1;
      pw_dest <= target_reg;
      pw_prio <= notify_priority_reg;
      pw_src <= SRC_ID;
      pw_hop <= HOP_COUNT;
      pw_payload <= {errstat_word | {31'h0, 1'b1}, errdet_now_word, impl_word, lt_err_detect};
      pw_to_mc <= mc_group_hit;
      pw_mc_mask <= mc_group_hit ? (mc_group_mask & ~own_bit) : '0;
    end
  end

  // Device-level outstanding view; this instance owns only its own bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outstanding_reg <= '0;
    end else begin
      outstanding_reg <= issue ? own_bit : (clear_pending ? '0 : (notify_pending_reg ? own_bit : '0));
    end
  end

  // Read data one cycle after the strobe, zero elsewhere and for unmapped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= ZERO_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        MODE_OFS: reg_rdata <= {31'h0, notify_disable_reg};
        TARGET_OFS: reg_rdata <= {16'h0, target_reg};
        RESEND_OFS: reg_rdata <= {8'h0, resend_interval_reg};
        PRIO_OFS: reg_rdata <= {30'h0, notify_priority_reg};
        ERRSTAT_OFS: reg_rdata <= errstat_word;
        ERRDET_OFS: reg_rdata <= errdet_word;
        INTSTAT_OFS: reg_rdata <= intstat_word;
        INTEN_OFS: reg_rdata <= inten_reg;
        CAPTURE_OFS: reg_rdata <= capture_reg;
        OUTST_OFS: reg_rdata <= {{(32-NUM_PORTS){1'b0}}, outstanding_reg};
        LTCTL_OFS: reg_rdata <= {8'h0, link_timeout_ctrl_reg};
        default: reg_rdata <= ZERO_WORD;
      endcase
    end else begin
      reg_rdata <= ZERO_WORD;
    end
  end

  // Checks
  sequence s_issue;
    issue;
  endsequence
  sequence s_sent;
    pw_valid && pw_dest == $past(target_reg);
  endsequence
  sequence s_clear_quiet;
    (state_reg == ST_WAIT && clear_pending && !timer_expired) ##1 !issue;
  endsequence

  a_issue_sends: assert property (@(posedge clk) disable iff (!rst_n)
    s_issue |=> s_sent) else $error("issue did not raise a packet");
  a_disable_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    notify_disable_reg |-> !issue) else $error("port-write while disabled");
  a_masked_silent: assert property (@(posedge clk) disable iff (!rst_n)
    (inten_reg[ERR_W-1:0] == '0 && (impl_evt & impl_en) == '0) |-> !issue) else $error("port-write for a masked event");
  a_one_outstanding: assert property (@(posedge clk) disable iff (!rst_n)
    notify_pending_reg |-> !issue) else $error("second port-write while pending");
  a_pending_set: assert property (@(posedge clk) disable iff (!rst_n)
    issue |=> notify_pending_reg) else $error("pending not set on issue");
  a_fixed_fields: assert property (@(posedge clk) disable iff (!rst_n)
    pw_valid |-> (pw_src == SRC_ID && pw_hop == HOP_COUNT)) else $error("bad source or hop");
  a_port_id: assert property (@(posedge clk) disable iff (!rst_n)
    pw_valid |-> pw_payload[PAYLOAD_W-64-1 -: PORTID_W] == PORT_NUM) else $error("bad port id field");
  a_mc_no_self: assert property (@(posedge clk) disable iff (!rst_n)
    pw_valid |-> (pw_mc_mask & own_bit) == '0) else $error("own port in multicast mask");
  a_resend_timer: assert property (@(posedge clk) disable iff (!rst_n)
    (timer_expired && notify_pending_reg && !pw_valid) |=> pw_valid) else $error("no resend on expiry");
  a_clear_idles: assert property (@(posedge clk) disable iff (!rst_n)
    s_clear_quiet |=> state_reg == ST_IDLE) else $error("clear did not idle");
  a_ack_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    ack_wait_expired |=> errdet_reg[ERR_ACK_WAIT]) else $error("time-out bit not set");

  // Packet contents, capture and side views
  a_payload_cause: assert property (@(posedge clk) disable iff (!rst_n)
    issue |=> (pw_payload[PAYLOAD_W-64 +: ERR_W] & $past(err_evt)) == $past(err_evt))
    else $error("payload lacks its cause");
  a_impl_copy: assert property (@(posedge clk) disable iff (!rst_n)
    issue |=> (pw_payload[PAYLOAD_W-96+IMPL_LSB +: IMPL_W] & $past(impl_evt)) == $past(impl_evt))
    else $error("payload lacks status event");
  a_prio_field: assert property (@(posedge clk) disable iff (!rst_n)
    issue |=> pw_prio == $past(notify_priority_reg)) else $error("bad packet priority");
  a_mc_route: assert property (@(posedge clk) disable iff (!rst_n)
    issue |=> pw_to_mc == $past(mc_group_hit)) else $error("bad multicast routing");
  a_unicast_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (pw_valid && !pw_to_mc) |-> pw_mc_mask == '0) else $error("mask on a unicast packet");
  a_outst_view: assert property (@(posedge clk) disable iff (!rst_n)
    outstanding_reg == (notify_pending_reg ? own_bit : '0)) else $error("outstanding view wrong");
  a_ackid_nocap: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_bad_ackid && !ev_protocol && !ev_unsol_ack) |=> $stable(capture_reg))
    else $error("ackid fault captured");
  a_delin_nocap: assert property (@(posedge clk) disable iff (!rst_n)
    (ev_delineation && !ev_protocol && !ev_unsol_ack) |=> $stable(capture_reg))
    else $error("delineation fault captured");
  a_clear_refused: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_errstat && notify_pending_reg && errdet_reg != '0) |=> notify_pending_reg)
    else $error("pending cleared too early");

endmodule : port_write_notifier

// [verilog/pwn_pkg.sv]
// Constants for the port-write notifier: register map, field layout, packet fields.
// Assumes a 32-bit plain register port with byte addresses.
package pwn_pkg;
  // Register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] TARGET_OFS = 8'h04;
  localparam logic [7:0] RESEND_OFS = 8'h08;
  localparam logic [7:0] PRIO_OFS = 8'h0c;
  localparam logic [7:0] ERRSTAT_OFS = 8'h10;
  localparam logic [7:0] ERRDET_OFS = 8'h14;
  localparam logic [7:0] INTSTAT_OFS = 8'h18;
  localparam logic [7:0] INTEN_OFS = 8'h1c;
  localparam logic [7:0] CAPTURE_OFS = 8'h20;
  localparam logic [7:0] OUTST_OFS = 8'h24;
  localparam logic [7:0] LTCTL_OFS = 8'h28;
  // Field positions
  localparam int DISABLE_BIT = 0;
  localparam int PENDING_BIT = 0;
  localparam int PRIO_LSB = 0;
  localparam int PRIO_W = 2;
  localparam int DEST_W = 16;
  localparam int ERR_W = 5;
  localparam int ERR_BAD_ACKID = 0;
  localparam int ERR_PROTOCOL = 1;
  localparam int ERR_DELIN = 2;
  localparam int ERR_UNSOL_ACK = 3;
  localparam int ERR_ACK_WAIT = 4;
  localparam int IMPL_LSB = 12;
  localparam int IMPL_W = 12;
  localparam int PORTID_LSB = 24;
  localparam int PORTID_W = 8;
  // Reset values and fixed packet fields
  localparam logic [PRIO_W-1:0] PRIO_RESET = 2'h3;
  localparam logic [7:0] SRC_ID = 8'h00;
  localparam logic [7:0] HOP_COUNT = 8'hff;
  localparam int PAYLOAD_BYTES = 16;
  localparam int PAYLOAD_W = PAYLOAD_BYTES * 8;
  // Enable mask covering implementation bits and error bits
  localparam logic [31:0] ERR_MASK = 32'h0000001f;
  localparam logic [31:0] IMPL_MASK = 32'h00fff000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage : pwn_pkg
